// ### verilog/tzp_regs.svh
// Purpose: Offsets, field positions, reset values of the zone profile register
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef TZP_REGS_SVH
`define TZP_REGS_SVH
`define TZP_PROFILE_OFFSET  8'h0C
`define TZP_COOL_ISET_LSB   6
`define TZP_WARM_ISET_LSB   4
`define TZP_VT2_LSB         2
`define TZP_VT3_LSB         0
`define TZP_PROFILE_RESET   8'h75
`define TZP_FRAC_NONE       8'h00
`define TZP_FRAC_20         8'h14
`define TZP_FRAC_50         8'h32
`define TZP_FRAC_100        8'h64
`define TZP_VT2_CODE0       16'h1BA3
`define TZP_VT2_CODE1       16'h1AA9
`define TZP_VT2_CODE2       16'h197D
`define TZP_VT2_CODE3       16'h1851
`define TZP_VT3_CODE0       16'h12D9
`define TZP_VT3_CODE1       16'h117B
`define TZP_VT3_CODE2       16'h0FEB
`define TZP_VT3_CODE3       16'h0EBF
`endif

// ### verilog/tzp_pkg.sv
// Purpose: Types of the zone profile block
// Assumes: Nothing
// Notes:   Thresholds in hundredths of a percent
package tzp_pkg;
   typedef enum logic [1:0] {
      TZP_ZONE_NORMAL = 2'b00,
      TZP_ZONE_COOL   = 2'b01,
      TZP_ZONE_WARM   = 2'b10,
      TZP_ZONE_OFF    = 2'b11
   } tzp_zone_t;
   typedef struct packed {
      logic [1:0] cool_iset;
      logic [1:0] warm_iset;
      logic [1:0] vt2;
      logic [1:0] vt3;
   } tzp_profile_t;
   typedef struct packed {
      tzp_profile_t prof;
      logic         rst_pend;
      logic         wd_flag;
      logic [7:0]   frac;
      logic         timer_2x;
   } tzp_state_t;
endpackage

// ### verilog/tzp_frac_if.sv
// Purpose: Carries a zone current code to the decoder and back
// Assumes: One clock
// Notes:   Combinational decode
`timescale 1ns/1ps
interface tzp_frac_if;
   logic [1:0] code;
   logic [7:0] frac;
   logic       full;
   modport user (output code, input frac, input full);
   modport dec  (input code, output frac, output full);
endinterface

// ### verilog/tzp_frac_dec.sv
// Purpose: Maps a 2-bit zone current code to a percent of base current
// Assumes: Codes are always legal
// Notes:   Pure logic
`timescale 1ns/1ps
`include "tzp_regs.svh"
module tzp_frac_dec
   import tzp_pkg::*;
(
   tzp_frac_if.dec f
);
   always_comb begin
      unique case (f.code)
         2'b00: f.frac = `TZP_FRAC_NONE;
         2'b01: f.frac = `TZP_FRAC_20;
         2'b10: f.frac = `TZP_FRAC_50;
         2'b11: f.frac = `TZP_FRAC_100;
      endcase
      f.full = (f.code == 2'b11);
   end
endmodule

// ### verilog/tzp_profile.sv
// Purpose: Temperature-zone charge profile register and its decode
// Assumes: Register write port from the serial register engine on core_clk
// Notes:   Zone and watchdog inputs come from other clock domains
//
// Contract
// - Cool zone current: 00 none, 01 20%, 10 50%, 11 100% of base.
// - Warm zone current uses its own code with the same mapping.
// - A 100% zone code never doubles the safety timer period.
// - Cool boundary code gives 70.75, 68.25, 65.25 or 62.25 percent.
// - Warm boundary code gives 48.25, 44.75, 40.75 or 37.75 percent.
// - Power-on defaults: cool 01, warm 11, cool boundary 01, warm boundary 01.
// - Register-reset request restores defaults, resets timer, and stays pending until a cycle after the request drops.
// - Watchdog expiry enters default mode and flags the fault.
`timescale 1ns/1ps
`include "tzp_regs.svh"
module tzp_profile
   import tzp_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   input  wire logic        reg_rst_req,
   output logic             reg_rst_busy,
   // Charger links
   input  wire logic [1:0]  zone_in,
   input  wire logic        wd_expire,
   input  wire logic        host_ack,
   output logic      [7:0]  charge_fraction,
   output logic             safety_timer_2x,
   output logic             safety_timer_rst,
   output logic      [15:0] cool_boundary_threshold,
   output logic      [15:0] warm_boundary_threshold,
   output logic             wd_fault
);
   tzp_state_t q;
   tzp_state_t next_q;
   logic [1:0] zone_s1;
   logic [1:0] zone_s2;
   logic       wd_s1;
   logic       wd_s2;
   logic       wd_s3;
   tzp_zone_t  zone;
   logic       wd_rise;
   logic       hit;

   tzp_frac_if cool_f ();
   tzp_frac_if warm_f ();
   tzp_frac_dec u_cool (.f(cool_f.dec));
   tzp_frac_dec u_warm (.f(warm_f.dec));

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Zone bits sync alone; a changing code may show one odd value for a cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         zone_s1 <= 2'h0;
         zone_s2 <= 2'h0;
         wd_s1   <= 1'b0;
         wd_s2   <= 1'b0;
         wd_s3   <= 1'b0;
      end else if (clk_en) begin
         zone_s1 <= zone_in;
         zone_s2 <= zone_s1;
         wd_s1   <= wd_expire;
         wd_s2   <= wd_s1;
         wd_s3   <= wd_s2;
      end
   end
   assign zone    = tzp_zone_t'(zone_s2);
   // Detector idles low like the pin, so reset never fakes an expiry
   assign wd_rise = wd_s2 & ~wd_s3;
   // Only one register lives here; other addresses read zero
   assign hit     = (reg_addr == `TZP_PROFILE_OFFSET);

   assign cool_f.code = q.prof.cool_iset;
   assign warm_f.code = q.prof.warm_iset;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_q = q;
      if (reg_wr && hit) begin
         next_q.prof = tzp_profile_t'(reg_wdata);
      end
      // Busy flag is the request registered, so it drops one cycle after the request drops
      next_q.rst_pend = reg_rst_req;
      // Restore lands on top of a host write in the same cycle
      if (q.rst_pend || wd_rise) begin
         next_q.prof = tzp_profile_t'(`TZP_PROFILE_RESET);
      end
      // Set beats the host clear
      if (wd_rise) begin
         next_q.wd_flag = 1'b1;
      end else if (host_ack) begin
         next_q.wd_flag = 1'b0;
      end
      unique case (zone)
         TZP_ZONE_COOL: begin
            next_q.frac     = cool_f.frac;
            next_q.timer_2x = ~cool_f.full;
         end
         TZP_ZONE_WARM: begin
            next_q.frac     = warm_f.frac;
            next_q.timer_2x = ~warm_f.full;
         end
         TZP_ZONE_NORMAL: begin
            next_q.frac     = `TZP_FRAC_100;
            next_q.timer_2x = 1'b0;
         end
         TZP_ZONE_OFF: begin
            next_q.frac     = `TZP_FRAC_NONE;
            next_q.timer_2x = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '{prof: tzp_profile_t'(`TZP_PROFILE_RESET), rst_pend: 1'b0,
                wd_flag: 1'b0, frac: `TZP_FRAC_NONE, timer_2x: 1'b0};
      end else if (clk_en) begin
         q <= next_q;
      end
   end

   // ---------------------------------------------------------------
   // Threshold decode
   // ---------------------------------------------------------------
   // Values in hundredths of a percent of the thermistor ratio
   always_comb begin
      unique case (q.prof.vt2)
         2'b00: cool_boundary_threshold = `TZP_VT2_CODE0;
         2'b01: cool_boundary_threshold = `TZP_VT2_CODE1;
         2'b10: cool_boundary_threshold = `TZP_VT2_CODE2;
         2'b11: cool_boundary_threshold = `TZP_VT2_CODE3;
      endcase
      unique case (q.prof.vt3)
         2'b00: warm_boundary_threshold = `TZP_VT3_CODE0;
         2'b01: warm_boundary_threshold = `TZP_VT3_CODE1;
         2'b10: warm_boundary_threshold = `TZP_VT3_CODE2;
         2'b11: warm_boundary_threshold = `TZP_VT3_CODE3;
      endcase
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign reg_rdata        = (reg_rd && hit) ? q.prof : 8'h00;
   assign reg_rst_busy     = q.rst_pend;
   assign safety_timer_rst = q.rst_pend;
   assign charge_fraction  = q.frac;
   assign safety_timer_2x  = q.timer_2x;
   assign wd_fault         = q.wd_flag;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst || !clk_en);
   // Checks sleep while the clock enable holds state

   a_cool_frac_map: assert property ((zone == TZP_ZONE_COOL) |=>
         (charge_fraction == $past(cool_f.frac))) else $error("cool fraction wrong");
   a_warm_frac_map: assert property ((zone == TZP_ZONE_WARM) |=>
         (charge_fraction == $past(warm_f.frac))) else $error("warm fraction wrong");
   a_full_no_double: assert property ((zone == TZP_ZONE_COOL && q.prof.cool_iset == 2'b11) |=>
         !safety_timer_2x) else $error("timer doubled at full current");
   a_vt2_decode: assert property ((q.prof.vt2 == 2'b01) |->
         (cool_boundary_threshold == 16'h1AA9)) else $error("cool boundary wrong");
   a_vt3_decode: assert property ((q.prof.vt3 == 2'b11) |->
         (warm_boundary_threshold == 16'h0EBF)) else $error("warm boundary wrong");
   a_rst_defaults: assert property ($rose(q.rst_pend) |=>
         (q.prof == 8'h75) && (q.rst_pend == $past(reg_rst_req))) else $error("reset request not restored");
   a_rst_req_busy: assert property (reg_rst_req |=> reg_rst_busy ##1 (reg_rst_busy == $past(reg_rst_req)))
      else $error("busy flag wrong");
   a_wd_fault_set: assert property (wd_rise |=> wd_fault && (q.prof == 8'h75))
      else $error("watchdog not handled");
   a_wd_defaults: assert property ((wd_rise && !(reg_wr && hit)) |=> (reg_rdata == 8'h75) || !(reg_rd && hit))
      else $error("watchdog defaults wrong");
   a_power_on: assert property ($fell(rst) |-> (q.prof == 8'h75))
      else $error("power-on default wrong");
   a_cool_none: assert property ((zone == TZP_ZONE_COOL && q.prof.cool_iset == 2'b00) |=>
         (charge_fraction == 8'h00)) else $error("cool zone charges at code zero");
   a_warm_half: assert property ((zone == TZP_ZONE_WARM && q.prof.warm_iset == 2'b10) |=>
         (charge_fraction == 8'h32)) else $error("warm half fraction wrong");
   a_warm_no_double: assert property ((zone == TZP_ZONE_WARM && q.prof.warm_iset == 2'b11) |=>
         !safety_timer_2x) else $error("timer doubled at full warm current");
   a_vt2_cold_end: assert property ((q.prof.vt2 == 2'b00) |->
         (cool_boundary_threshold == 16'h1BA3)) else $error("cool boundary code zero wrong");
   a_vt2_warm_end: assert property ((q.prof.vt2 == 2'b11) |->
         (cool_boundary_threshold == 16'h1851)) else $error("cool boundary code three wrong");
   a_vt3_cool_end: assert property ((q.prof.vt3 == 2'b00) |->
         (warm_boundary_threshold == 16'h12D9)) else $error("warm boundary code zero wrong");
   a_vt3_mid_code: assert property ((q.prof.vt3 == 2'b10) |->
         (warm_boundary_threshold == 16'h0FEB)) else $error("warm boundary code two wrong");
   a_timer_rst_req: assert property (reg_rst_req |=> safety_timer_rst)
      else $error("safety timer not reset");
   a_wd_flag_clear: assert property ((host_ack && !wd_rise) |=> !wd_fault)
      else $error("watchdog flag not cleared");

   // ---------------------------------------------------------------
   // Cover points
   // ---------------------------------------------------------------
   c_cool_zone:  cover property (zone == TZP_ZONE_COOL ##1 charge_fraction == 8'h14);
   c_warm_full:  cover property (zone == TZP_ZONE_WARM ##1 charge_fraction == 8'h64);
   c_reg_reset:  cover property (reg_wr && hit ##1 reg_rst_req ##2 q.prof == 8'h75);
   c_rst_held:   cover property (reg_rst_req ##1 reg_rst_req ##1 !reg_rst_req);
   c_watchdog:   cover property (wd_rise ##1 wd_fault ##[1:5] !wd_fault);
endmodule

// ### verif/tzp_host_model.sv
// Purpose: Host side of the profile register port
// Assumes: Drives on the falling edge
// Notes:   Idle write data is inverted so stale bytes never match
`timescale 1ns/1ps
module tzp_host_model (
   // Clock
   input  wire logic       core_clk,
   // Register port
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_rd = 1'b0;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   // Read is a level, held until the next access
   task automatic rd(input logic [7:0] a);
      @(negedge core_clk);
      reg_rd = 1'b1;
      reg_addr = a;
   endtask
endmodule

// ### verif/tb.sv
// Purpose: Self-checking bench of the zone profile register
// Assumes: Host model drives the register port
// Notes:   Expectations queued, compared by a watcher
`timescale 1ns/1ps
module tb;
   import tzp_pkg::*;
   logic        core_clk = 1'b0, rst = 1'b1, reg_rst_req = 1'b0;
   logic        wd_expire = 1'b0, host_ack = 1'b0, probe = 1'b0, clk_en = 1'b1;
   logic [1:0]  zone_in = 2'b00;
   logic [2:0]  sel = 3'h0;
   logic        reg_wr, reg_rd, busy, tmr_2x, tmr_rst, wd_fault;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, frac, w;
   logic [15:0] cool_thr, warm_thr, obs;
   logic [15:0] exp_q[$];
   int          n_mismatch = 0, samples_checked = 0, cyc = 0, seed = 64252;
   logic [7:0]  frac_t[4] = '{8'h00, 8'h14, 8'h32, 8'h64};
   logic [15:0] vt2_t[4] = '{16'h1BA3, 16'h1AA9, 16'h197D, 16'h1851};
   logic [15:0] vt3_t[4] = '{16'h12D9, 16'h117B, 16'h0FEB, 16'h0EBF};
   string       nm[7] = '{"rdata", "cool_thr", "warm_thr", "fraction", "timer_2x", "busy_rst", "wd_fault"};

   tzp_host_model u_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
                          .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   tzp_profile u_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rst_req(reg_rst_req),
      .reg_rst_busy(busy), .zone_in(zone_in), .wd_expire(wd_expire), .host_ack(host_ack),
      .charge_fraction(frac), .safety_timer_2x(tmr_2x), .safety_timer_rst(tmr_rst),
      .cool_boundary_threshold(cool_thr), .warm_boundary_threshold(warm_thr), .wd_fault(wd_fault));

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   task automatic stop_test();
      $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] e);
      samples_checked++;
      if (seen !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", n, e, seen);
      end
   endtask

   // Note an expectation; the watcher samples it at the next rising edge
   task automatic expect_v(input logic [2:0] s, input logic [15:0] e);
      @(negedge core_clk);
      sel = s;
      probe = 1'b1;
      exp_q.push_back(e);
      @(negedge core_clk);
      probe = 1'b0;
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc > 3000) begin
         n_mismatch++;
         stop_test();
      end
      if (probe) begin
         case (sel)
            3'h0: obs = {8'h00, reg_rdata};
            3'h1: obs = cool_thr;
            3'h2: obs = warm_thr;
            3'h3: obs = {8'h00, frac};
            3'h4: obs = {15'h0000, tmr_2x};
            3'h5: obs = {14'h0000, busy, tmr_rst};
            default: obs = {15'h0000, wd_fault};
         endcase
         chk(nm[sel], obs, exp_q.pop_front());
      end
   end

   initial begin
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      u_host.rd(8'h0C);
      expect_v(3'h0, 16'h0075);
      expect_v(3'h1, 16'h1AA9);
      expect_v(3'h2, 16'h117B);
      for (int i = 0; i < 8; i++) begin
         // First four cover every code of every field, then random bytes
         w = (i < 4) ? ({4{i[1:0]}} ^ 8'h33) : 8'($random(seed));
         u_host.wr(8'h0C, w);
         u_host.wr(8'h0B, ~w);
         u_host.rd(8'h0C);
         expect_v(3'h0, {8'h00, w});
         expect_v(3'h1, vt2_t[w[3:2]]);
         expect_v(3'h2, vt3_t[w[1:0]]);
         zone_in = 2'b01;
         repeat (4) @(negedge core_clk);
         expect_v(3'h3, {8'h00, frac_t[w[7:6]]});
         if (w[7:6] == 2'b11) expect_v(3'h4, 16'h0000);
         zone_in = 2'b10;
         repeat (4) @(negedge core_clk);
         expect_v(3'h3, {8'h00, frac_t[w[5:4]]});
         if (w[5:4] == 2'b11) expect_v(3'h4, 16'h0000);
      end
      // Frozen clock enable refuses the write and holds every field
      clk_en = 1'b0;
      u_host.wr(8'h0C, ~w);
      u_host.rd(8'h0C);
      expect_v(3'h0, {8'h00, w});
      clk_en = 1'b1;
      zone_in = 2'b11;
      repeat (4) @(negedge core_clk);
      expect_v(3'h3, 16'h0000);
      zone_in = 2'b00;
      repeat (4) @(negedge core_clk);
      expect_v(3'h3, 16'h0064);
      u_host.rd(8'h0B);
      expect_v(3'h0, 16'h0000);
      u_host.wr(8'h0C, 8'h00);
      // Request held two cycles right after the write; busy follows it
      reg_rst_req = 1'b1;
      expect_v(3'h5, 16'h0003);
      reg_rst_req = 1'b0;
      expect_v(3'h5, 16'h0000);
      u_host.rd(8'h0C);
      expect_v(3'h0, 16'h0075);
      u_host.wr(8'h0C, 8'h8A);
      wd_expire = 1'b1;
      repeat (5) @(negedge core_clk);
      expect_v(3'h6, 16'h0001);
      u_host.rd(8'h0C);
      expect_v(3'h0, 16'h0075);
      host_ack = 1'b1;
      @(negedge core_clk);
      host_ack = 1'b0;
      expect_v(3'h6, 16'h0000);
      repeat (2) @(negedge core_clk);
      stop_test();
   end
endmodule
